// file: rtl/pwt_params.svh
// Offsets, field positions, reset values and timing counts of the pulse width timer
`ifndef PWT_PARAMS_SVH
`define PWT_PARAMS_SVH

// ************************************************************
// Register offsets (byte addresses on the plain register port)
// ************************************************************
`define PWT_OFS_TMRA_CTRL   8'h00
`define PWT_OFS_TMRA_PRE    8'h01
`define PWT_OFS_TMRA_CNT    8'h02
`define PWT_OFS_TMRB_CTRL   8'h03
`define PWT_OFS_TMRB_PRE_LO 8'h04
`define PWT_OFS_TMRB_PRE_HI 8'h05
`define PWT_OFS_TMRB_CNT_LO 8'h06
`define PWT_OFS_TMRB_CNT_HI 8'h07
`define PWT_OFS_MISC        8'h08
`define PWT_OFS_PORT_A_DATA 8'h09
`define PWT_OFS_PORT_A_DIR  8'h0A
`define PWT_OFS_INT_CTRL    8'h0B

// ************************************************************
// Field positions
// ************************************************************
`define PWT_MODE_HI      7
`define PWT_MODE_LO      6
`define PWT_B_CLK_SEL    5
`define PWT_RUN          4
`define PWT_EDGE         3
`define PWT_PSC_HI       2
`define PWT_PSC_LO       0
`define PWT_FD_EN        0
`define PWT_FD_SEL       1
`define PWT_PA5          5
`define PWT_INT_A_EN     0
`define PWT_INT_B_EN     1
`define PWT_INT_A_FLAG   2
`define PWT_INT_B_FLAG   3

// ************************************************************
// Reset values
// ************************************************************
`define PWT_RST_CTRL_A   8'h08
`define PWT_RST_CTRL_B   8'h08
`define PWT_RST_MISC     8'h00
`define PWT_RST_PORT_DIR 8'hFF
`define PWT_RST_PORT_DAT 8'h00
`define PWT_RST_INT      8'h00

// ************************************************************
// Timing counts
// ************************************************************
`define PWT_SUB_DIV      16'd7629
`define PWT_SYS_DIV4     2'd3

`endif

// file: rtl/pwt_pkg.sv
// Types shared by the pulse width timer modules
package pwt_pkg;
	typedef enum logic [1:0] {
		PWT_MODE_EVT_CMP = 2'h0,
		PWT_MODE_EVT_PIN = 2'h1,
		PWT_MODE_TIMER   = 2'h2,
		PWT_MODE_PWM     = 2'h3
	} pwt_mode_t;

	typedef enum logic [2:0] {
		PWT_ST_IDLE  = 3'b001,
		PWT_ST_ARMED = 3'b010,
		PWT_ST_COUNT = 3'b100
	} pwt_state_t;
endpackage

// file: rtl/pwt_tick_if.sv
// Tick and edge bundle passed from the top into a timer channel
`timescale 1ns/1ns
`default_nettype none
interface pwt_tick_if;
	logic tick;
	logic cmp_evt;
	logic pin_rise;
	logic pin_fall;
	modport src (output tick, output cmp_evt, output pin_rise, output pin_fall);
	modport dst (input tick, input cmp_evt, input pin_rise, input pin_fall);
endinterface
`default_nettype wire

// file: rtl/pwt_channel.sv
// One timer channel: mode sequencing, counting, reload and overflow
`timescale 1ns/1ns
`default_nettype none
`include "pwt_params.svh"
module pwt_channel import pwt_pkg::*; #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	pwt_tick_if.dst           tk,
	input  wire logic [1:0]   mode,
	input  wire logic         edge_sel,
	input  wire logic         run_en,
	input  wire logic         run_set,
	input  wire logic         pre_wr,
	input  wire logic [W-1:0] pre_val,
	output logic [W-1:0]      count,
	output logic              ovf,
	output logic              run_clr
);
	pwt_state_t state;
	pwt_state_t next_state;
	logic [W-1:0] preload;
	logic start_edge;
	logic stop_edge;
	logic inc;

	// ************************************************************
	// Edge decode
	// ************************************************************
	// Low edge select starts on falling, stops on rising
	assign start_edge = edge_sel ? tk.pin_rise : tk.pin_fall;
	assign stop_edge  = edge_sel ? tk.pin_fall : tk.pin_rise;

	always_comb begin
		inc = 1'b0;
		case (mode)
			PWT_MODE_EVT_CMP: inc = run_en & tk.cmp_evt;
			PWT_MODE_EVT_PIN: inc = run_en & (edge_sel ? tk.pin_fall : tk.pin_rise);
			PWT_MODE_TIMER:   inc = run_en & tk.tick;
			PWT_MODE_PWM:     inc = (state == PWT_ST_COUNT) & tk.tick;
			default:          inc = 1'b0;
		endcase
	end

	// ************************************************************
	// Pulse width sequencing
	// ************************************************************
	always_comb begin
		next_state = state;
		case (state)
			// Arm from the stored bits: the write strobe cycle still shows the old mode
			PWT_ST_IDLE:  if (run_en && mode == PWT_MODE_PWM) next_state = PWT_ST_ARMED;
			PWT_ST_ARMED: if (start_edge) next_state = PWT_ST_COUNT;
			PWT_ST_COUNT: if (stop_edge) next_state = PWT_ST_IDLE;
			default:      next_state = PWT_ST_IDLE;
		endcase
		// Software abort or leaving the mode drops back to idle
		if (mode != PWT_MODE_PWM || !run_en) next_state = PWT_ST_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) state <= PWT_ST_IDLE;
		else        state <= next_state;
	end

	// Only pulse width mode clears the run bit by hardware
	assign run_clr = (mode == PWT_MODE_PWM) && (state == PWT_ST_COUNT) && stop_edge;

	// ************************************************************
	// Counter with preload
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) preload <= '0;
		else if (pre_wr) preload <= pre_val;
	end

	assign ovf = inc && (count == {W{1'b1}});

	// Stopped timer takes preload writes at once; running one waits for overflow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) count <= '0;
		else if (pre_wr && !run_en) count <= pre_val;
		else if (ovf) count <= preload;
		else if (inc) count <= count + 1'b1;
	end
endmodule
`default_nettype wire

// file: rtl/pwt_top.sv
// Pulse width timer pair with frequency divider and register port
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "pwt_params.svh"
module pwt_top import pwt_pkg::*; (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       tmr_a_input_pin,
	input  wire logic       tmr_b_input_pin,
	input  wire logic       cmp1_out,
	input  wire logic       cmp2_out,
	input  wire logic       port_a_bit5_in,
	output logic            port_a_bit5_out,
	output logic            port_a_bit5_oe,
	output logic            freq_divider_out,
	output logic            timer_irq
);
	logic [1:0]  rst_sync;
	logic        rst_n;
	logic [7:0]  ctrl_a;
	logic [7:0]  ctrl_b;
	logic [7:0]  misc;
	logic [7:0]  port_data;
	logic [7:0]  port_dir;
	logic [7:0]  int_ctrl;
	logic [7:0]  pre_b_lo_buf;
	logic [7:0]  cnt_b_hi_latch;
	logic [6:0]  psc_cnt;
	logic [15:0] sub_cnt;
	logic [1:0]  div4_cnt;
	logic        tick_a;
	logic        tick_b;
	logic [2:0]  sync_a;
	logic [2:0]  sync_b;
	logic [2:0]  sync_c1;
	logic [2:0]  sync_c2;
	logic [7:0]  cnt_a;
	logic [15:0] cnt_b;
	logic        ovf_a;
	logic        ovf_b;
	logic        clr_a;
	logic        clr_b;
	logic        set_a;
	logic        set_b;
	logic        fd_q;
	logic        fd_ovf;
	pwt_tick_if  tk_a ();
	pwt_tick_if  tk_b ();

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = (a == ofs);
	endfunction

	// ************************************************************
	// Reset release
	// ************************************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) rst_sync <= 2'h0;
		else         rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ************************************************************
	// Clock enables
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) psc_cnt <= 7'h00;
		else        psc_cnt <= psc_cnt + 7'h01;
	end

	// Divide by 2^code: low code bits of the free counter all ones
	always_comb begin
		tick_a = 1'b1;
		for (int i = 0; i < 7; i++) begin
			if (i < int'(ctrl_a[`PWT_PSC_HI:`PWT_PSC_LO]) && !psc_cnt[i]) tick_a = 1'b0;
		end
	end

	// Sub clock is modelled as a slow enable from the system clock
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sub_cnt  <= 16'h0000;
			div4_cnt <= 2'h0;
		end else begin
			sub_cnt  <= (sub_cnt == `PWT_SUB_DIV) ? 16'h0000 : sub_cnt + 16'h0001;
			div4_cnt <= div4_cnt + 2'h1;
		end
	end
	assign tick_b = ctrl_b[`PWT_B_CLK_SEL] ? (sub_cnt == `PWT_SUB_DIV)
	                                       : (div4_cnt == `PWT_SYS_DIV4);

	// ************************************************************
	// Input synchronisers and edge detection
	// ************************************************************
	// Stage 0 feeds stage 1 only; edges compare stages 1 and 2
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a  <= 3'h0;
			sync_b  <= 3'h0;
			sync_c1 <= 3'h0;
			sync_c2 <= 3'h0;
		end else begin
			sync_a  <= {sync_a[1:0], tmr_a_input_pin};
			sync_b  <= {sync_b[1:0], tmr_b_input_pin};
			sync_c1 <= {sync_c1[1:0], cmp1_out};
			sync_c2 <= {sync_c2[1:0], cmp2_out};
		end
	end

	assign tk_a.tick     = tick_a;
	assign tk_a.cmp_evt  = ctrl_a[`PWT_EDGE] ? (sync_c1[2] & ~sync_c1[1])
	                                         : (sync_c1[1] & ~sync_c1[2]);
	assign tk_a.pin_rise = sync_a[1] & ~sync_a[2];
	assign tk_a.pin_fall = ~sync_a[1] & sync_a[2];
	assign tk_b.tick     = tick_b;
	assign tk_b.cmp_evt  = ctrl_b[`PWT_EDGE] ? (sync_c2[2] & ~sync_c2[1])
	                                         : (sync_c2[1] & ~sync_c2[2]);
	assign tk_b.pin_rise = sync_b[1] & ~sync_b[2];
	assign tk_b.pin_fall = ~sync_b[1] & sync_b[2];

	// ************************************************************
	// Timer channels
	// ************************************************************
	assign set_a = reg_wr && wr_hit(reg_addr, `PWT_OFS_TMRA_CTRL) && reg_wdata[`PWT_RUN];
	assign set_b = reg_wr && wr_hit(reg_addr, `PWT_OFS_TMRB_CTRL) && reg_wdata[`PWT_RUN];

	pwt_channel #(.W(8)) u_tmr_a (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.tk      (tk_a),
		.mode    (ctrl_a[`PWT_MODE_HI:`PWT_MODE_LO]),
		.edge_sel(ctrl_a[`PWT_EDGE]),
		.run_en  (ctrl_a[`PWT_RUN]),
		.run_set (set_a),
		.pre_wr  (reg_wr && wr_hit(reg_addr, `PWT_OFS_TMRA_PRE)),
		.pre_val (reg_wdata),
		.count   (cnt_a),
		.ovf     (ovf_a),
		.run_clr (clr_a)
	);

	pwt_channel #(.W(16)) u_tmr_b (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.tk      (tk_b),
		.mode    (ctrl_b[`PWT_MODE_HI:`PWT_MODE_LO]),
		.edge_sel(ctrl_b[`PWT_EDGE]),
		.run_en  (ctrl_b[`PWT_RUN]),
		.run_set (set_b),
		.pre_wr  (reg_wr && wr_hit(reg_addr, `PWT_OFS_TMRB_PRE_HI)),
		.pre_val ({reg_wdata, pre_b_lo_buf}),
		.count   (cnt_b),
		.ovf     (ovf_b),
		.run_clr (clr_b)
	);

	// ************************************************************
	// Control registers
	// ************************************************************
	// A software set in the same cycle as a hardware clear wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) ctrl_a <= `PWT_RST_CTRL_A;
		else if (reg_wr && wr_hit(reg_addr, `PWT_OFS_TMRA_CTRL)) ctrl_a <= reg_wdata & 8'hDF;
		else if (clr_a) ctrl_a[`PWT_RUN] <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) ctrl_b <= `PWT_RST_CTRL_B;
		else if (reg_wr && wr_hit(reg_addr, `PWT_OFS_TMRB_CTRL)) ctrl_b <= reg_wdata & 8'hF8;
		else if (clr_b) ctrl_b[`PWT_RUN] <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) pre_b_lo_buf <= 8'h00;
		else if (reg_wr && wr_hit(reg_addr, `PWT_OFS_TMRB_PRE_LO)) pre_b_lo_buf <= reg_wdata;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) misc <= `PWT_RST_MISC;
		else if (reg_wr && wr_hit(reg_addr, `PWT_OFS_MISC)) misc <= reg_wdata & 8'hF3;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_data <= `PWT_RST_PORT_DAT;
			port_dir  <= `PWT_RST_PORT_DIR;
		end else if (reg_wr && wr_hit(reg_addr, `PWT_OFS_PORT_A_DATA)) begin
			port_data <= reg_wdata;
		end else if (reg_wr && wr_hit(reg_addr, `PWT_OFS_PORT_A_DIR)) begin
			port_dir <= reg_wdata;
		end
	end

	// Overflow flags: hardware set wins over software clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) int_ctrl <= `PWT_RST_INT;
		else begin
			if (reg_wr && wr_hit(reg_addr, `PWT_OFS_INT_CTRL)) int_ctrl <= reg_wdata & 8'h0F;
			if (ovf_a) int_ctrl[`PWT_INT_A_FLAG] <= 1'b1;
			if (ovf_b) int_ctrl[`PWT_INT_B_FLAG] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) timer_irq <= 1'b0;
		else timer_irq <= (int_ctrl[`PWT_INT_A_FLAG] & int_ctrl[`PWT_INT_A_EN])
		                | (int_ctrl[`PWT_INT_B_FLAG] & int_ctrl[`PWT_INT_B_EN]);
	end

	// ************************************************************
	// Frequency divider
	// ************************************************************
	assign fd_ovf = misc[`PWT_FD_SEL] ? ovf_b : ovf_a;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) fd_q <= 1'b0;
		else if (fd_ovf) fd_q <= ~fd_q;
	end

	assign freq_divider_out = fd_q;

	// Direction bit low means output; timer pin keeps its own direction
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_a_bit5_out <= 1'b0;
			port_a_bit5_oe  <= 1'b0;
		end else begin
			port_a_bit5_oe <= ~port_dir[`PWT_PA5];
			if (misc[`PWT_FD_EN]) port_a_bit5_out <= port_data[`PWT_PA5] & fd_q;
			else port_a_bit5_out <= port_data[`PWT_PA5];
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	// High byte read latches the low byte so a 16-bit read is coherent
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) cnt_b_hi_latch <= 8'h00;
		else if (reg_rd && wr_hit(reg_addr, `PWT_OFS_TMRB_CNT_HI)) cnt_b_hi_latch <= cnt_b[7:0];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				`PWT_OFS_TMRA_CTRL:   reg_rdata <= ctrl_a;
				`PWT_OFS_TMRA_CNT:    reg_rdata <= cnt_a;
				`PWT_OFS_TMRB_CTRL:   reg_rdata <= ctrl_b;
				`PWT_OFS_TMRB_CNT_LO: reg_rdata <= cnt_b_hi_latch;
				`PWT_OFS_TMRB_CNT_HI: reg_rdata <= cnt_b[15:8];
				`PWT_OFS_MISC:        reg_rdata <= misc;
				`PWT_OFS_PORT_A_DATA: reg_rdata <= {port_data[7:6], port_a_bit5_in, port_data[4:0]};
				`PWT_OFS_PORT_A_DIR:  reg_rdata <= port_dir;
				`PWT_OFS_INT_CTRL:    reg_rdata <= int_ctrl;
				default:              reg_rdata <= 8'h00;
			endcase
		end else reg_rdata <= 8'h00;
	end
endmodule
`default_nettype wire

// file: verification/pwt_chk.sv
// Port-level checker for the pulse width timer
`timescale 1ns/1ns
`default_nettype none
module pwt_chk (
	input wire logic       ref_clk,
	input wire logic       resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       port_a_bit5_out,
	input wire logic       port_a_bit5_oe,
	input wire logic       timer_irq
);
	// ************************************************************
	// Register shadows
	// ************************************************************
	logic       fd_en;
	logic [1:0] en0;
	logic [1:0] en1;
	logic [1:0] en2;
	logic       w09;
	logic       w0a;
	logic       w0b;
	assign w09 = reg_wr && reg_addr == 8'h09;
	assign w0a = reg_wr && reg_addr == 8'h0A;
	assign w0b = reg_wr && reg_addr == 8'h0B;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Enable history covers the two cycles the request lags a mask change
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			en0 <= 2'h0;
			en1 <= 2'h0;
			en2 <= 2'h0;
		end else begin
			en0 <= w0b ? reg_wdata[1:0] : en0;
			en1 <= en0;
			en2 <= en1;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fd_en <= 1'h0;
		end else if (reg_wr && reg_addr == 8'h08) begin
			fd_en <= reg_wdata[0];
		end
	end
	// ************************************************************
	// Assertions
	// ************************************************************
	a_oe_output: assert property (w0a && !reg_wdata[5] |-> ##3 port_a_bit5_oe)
		else $error("pin not driven after direction set to output");
	a_oe_input: assert property (w0a && reg_wdata[5] |-> ##3 !port_a_bit5_oe)
		else $error("pin driven after direction set to input");
	a_reset_oe: assert property ($rose(resetn) |-> !port_a_bit5_oe [*4])
		else $error("pin driven right after reset");
	a_data_low: assert property (w09 && !reg_wdata[5] |-> ##3 !port_a_bit5_out [*4])
		else $error("pin not low with data bit clear");
	a_out_plain: assert property (w09 && reg_wdata[5] && !fd_en |-> ##3 port_a_bit5_out)
		else $error("plain output does not follow data bit");
	a_irq_masked: assert property (w0b && reg_wdata[1:0] == 2'h0 |-> ##3 !timer_irq [*4])
		else $error("request seen with enables clear");
	a_irq_needs_en: assert property (timer_irq |-> (en0 | en1 | en2) != 2'h0)
		else $error("request without any enable");
	a_irq_holds: assert property (timer_irq && !w0b && !$past(w0b) && !$past(w0b, 2)
		|=> timer_irq)
		else $error("request dropped without software clear");
	c_irq: cover property ($rose(timer_irq));
	c_oe: cover property ($rose(port_a_bit5_oe));
	c_out: cover property ($changed(port_a_bit5_out));
endmodule
`default_nettype wire

// file: verification/pwt_pulse_src.sv
// Pulse source model driving one timer input pin
`timescale 1ns/1ns
`default_nettype none
module pwt_pulse_src (
	input  wire logic        clk,
	input  wire logic        idle_lvl,
	input  wire logic [15:0] width,
	input  wire logic        go,
	output logic             pin
);
	// ************************************************************
	// Pulse timing
	// ************************************************************
	logic [15:0] left = 16'h0000;
	// Pin shows the inverse of the idle level for width cycles
	always @(posedge clk) begin
		if (go) begin
			left <= width;
		end else if (left != 16'h0000) begin
			left <= left - 16'h0001;
		end
	end
	assign pin = idle_lvl ^ (left != 16'h0000);
endmodule
`default_nettype wire

// file: verification/test_pwt_top.sv
// Self-checking testbench for the pulse width timer
`timescale 1ns/1ns
`default_nettype none
module test_pwt_top;
	logic        ref_clk = 1'h0;
	logic        resetn = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [7:0]  reg_rdata;
	logic        pin_a;
	logic        pin_b;
	logic        cmp1 = 1'h0;
	logic        pa5_out;
	logic        pa5_oe;
	logic        irq;
	logic        fdo;
	logic        idle_a = 1'h1;
	logic        idle_b = 1'h0;
	logic [15:0] w = 16'h0000;
	logic        go_a = 1'h0;
	logic        go_b = 1'h0;
	int          mismatches = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [7:0]  d;
	logic [7:0]  h;
	int          t;
	always #2 ref_clk = ~ref_clk;
	pwt_top pwt_top_i (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tmr_a_input_pin(pin_a), .tmr_b_input_pin(pin_b), .cmp1_out(cmp1),
		.cmp2_out(1'h0), .port_a_bit5_in(1'h0), .port_a_bit5_out(pa5_out),
		.port_a_bit5_oe(pa5_oe), .freq_divider_out(fdo), .timer_irq(irq));
	pwt_pulse_src src_a (.clk(ref_clk), .idle_lvl(idle_a), .width(w), .go(go_a), .pin(pin_a));
	pwt_pulse_src src_b (.clk(ref_clk), .idle_lvl(idle_b), .width(w), .go(go_b), .pin(pin_b));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic conclude;
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a, d);
		chk(16'(d), 16'(e));
	endtask
	task automatic pls(input logic s, input logic [15:0] n);
		@(posedge ref_clk);
		w <= n;
		go_a <= !s;
		go_b <= s;
		@(posedge ref_clk);
		go_a <= 1'h0;
		go_b <= 1'h0;
		repeat (n + 8) @(posedge ref_clk);
	endtask
	task automatic tog(input int n, output int c);
		logic p;
		#1;
		c = 0;
		p = pa5_out;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			c += int'(pa5_out !== p);
			p = pa5_out;
		end
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		rchk(8'h00, 8'h08);
		rchk(8'h03, 8'h08);
		rchk(8'h08, 8'h00);
		rchk(8'h0A, 8'hFF);
		rchk(8'h0B, 8'h00);
		rchk(8'h40, 8'h00);
	endtask
	task automatic t_pw_fall;
		wr(8'h0A, 8'hFF);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'hD0);
		repeat (20) @(posedge ref_clk);
		rchk(8'h02, 8'h00);
		pls(1'h0, 16'h0028);
		rd(8'h02, h);
		chk(16'(h >= 8'h25 && h <= 8'h2B), 16'h0001);
		rchk(8'h00, 8'hC0);
		pls(1'h0, 16'h0014);
		rchk(8'h02, h);
		wr(8'h01, 8'h00);
		idle_a <= 1'h0;
		wr(8'h00, 8'hD0);
		repeat (20) @(posedge ref_clk);
		rchk(8'h02, 8'h00);
		idle_a <= 1'h1;
		repeat (20) @(posedge ref_clk);
		rchk(8'h02, 8'h00);
	endtask
	// Every prescaler code, rising start edge
	task automatic t_pw_psc;
		wr(8'h00, 8'h00);
		idle_a <= 1'h0;
		for (int k = 0; k < 8; k++) begin
			wr(8'h01, 8'h00);
			wr(8'h00, 8'hD8 | 8'(k));
			pls(1'h0, 16'h0080);
			rd(8'h02, d);
			t = int'(d) - (128 >> k);
			chk(16'(t >= -3 && t <= 3), 16'h0001);
			rchk(8'h00, 8'hC8 | 8'(k));
		end
	endtask
	task automatic t_ovf;
		wr(8'h01, 8'hFE);
		wr(8'h0B, 8'h01);
		wr(8'h08, 8'h01);
		wr(8'h0A, 8'hDF);
		wr(8'h09, 8'h20);
		wr(8'h00, 8'h90);
		repeat (10) @(posedge ref_clk);
		#1 chk(16'(irq), 16'h0001);
		chk(16'(pa5_oe), 16'h0001);
		rchk(8'h00, 8'h90);
		rchk(8'h0B, 8'h05);
		tog(16, t);
		chk(16'(t >= 4), 16'h0001);
		// Preload FE overflows every second cycle, so the divider flips once per two
		h[0] = fdo;
		repeat (2) @(posedge ref_clk);
		#1 chk(16'(fdo), 16'(!h[0]));
		wr(8'h09, 8'h00);
		repeat (3) @(posedge ref_clk);
		tog(12, t);
		chk(16'(t), 16'h0000);
		wr(8'h08, 8'h03);
		wr(8'h09, 8'h20);
		repeat (3) @(posedge ref_clk);
		tog(12, t);
		chk(16'(t), 16'h0000);
		h[0] = fdo;
		repeat (8) @(posedge ref_clk);
		#1 chk(16'(fdo), 16'(h[0]));
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h20);
		repeat (3) @(posedge ref_clk);
		#1 chk(16'(pa5_out), 16'h0001);
		wr(8'h0B, 8'h00);
		repeat (4) @(posedge ref_clk);
		#1 chk(16'(irq), 16'h0000);
		wr(8'h0A, 8'hFF);
		repeat (3) @(posedge ref_clk);
		#1 chk(16'(pa5_oe), 16'h0000);
	endtask
	task automatic t_evt;
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h50);
		repeat (3) pls(1'h0, 16'h0004);
		rchk(8'h02, 8'h03);
		wr(8'h00, 8'h58);
		repeat (2) pls(1'h0, 16'h0004);
		rchk(8'h02, 8'h05);
		rchk(8'h00, 8'h58);
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h10);
		repeat (2) begin
			cmp1 <= 1'h1;
			repeat (6) @(posedge ref_clk);
			cmp1 <= 1'h0;
			repeat (6) @(posedge ref_clk);
		end
		rchk(8'h02, 8'h02);
		wr(8'h00, 8'h00);
	endtask
	task automatic t_b;
		wr(8'h04, 8'h00);
		wr(8'h05, 8'h00);
		wr(8'h03, 8'hD8);
		pls(1'h1, 16'h0050);
		rd(8'h07, h);
		rd(8'h06, d);
		t = int'({h, d}) - 20;
		chk(16'(t >= -2 && t <= 2), 16'h0001);
		rchk(8'h03, 8'hC8);
	endtask
	// ************************************************************
	// Sequence and hang guard
	// ************************************************************
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude;
		end
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (3) @(posedge ref_clk);
		t_reset;
		t_pw_fall;
		t_pw_psc;
		t_ovf;
		t_evt;
		t_b;
		conclude;
	end
endmodule
bind pwt_top pwt_chk pwt_chk_i (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.port_a_bit5_out(port_a_bit5_out), .port_a_bit5_oe(port_a_bit5_oe),
	.timer_irq(timer_irq));
`default_nettype wire
